// ===== master_param_end.sv
// Module: master end of the parameter channel, AXI4-Lite controlled
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module master_param_end (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  output logic irq,
  // Link to drive
  param_chan_if.master link
);
  import param_chan_pkg::*;
  typedef enum logic [1:0] {IDLE, WAIT_CHECK, COMMIT, RELEASE_BIT} cmd_state_t;
  cmd_state_t state_reg;
  logic [15:0] ctrl_reg;
  logic [6:0] index_reg;
  logic [15:0] wdata_reg;
  logic [2:0] irq_status_reg;
  logic [2:0] irq_mask_reg;
  logic [2:0] irq_event;
  logic aw_hold, w_hold;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic go;
  logic [1:0] wait_reg;
  assign s_axi_awready = !aw_hold;
  assign s_axi_wready = !w_hold;
  assign s_axi_arready = !s_axi_rvalid;
  assign go = aw_hold && w_hold && !s_axi_bvalid && aw_addr_reg == REG_CTRL &&
    w_strb_reg[0] && w_data_reg[CTRL_GO];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (aw_hold && w_hold && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_reg <= REG_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Registers written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= '0;
      index_reg <= '0;
      wdata_reg <= '0;
      irq_mask_reg <= '0;
    end else if (aw_hold && w_hold && !s_axi_bvalid && w_strb_reg[0]) begin
      case (aw_addr_reg)
        REG_CTRL: ctrl_reg <= {15'h0000, w_data_reg[CTRL_RELEASE]};
        REG_INDEX: index_reg <= w_data_reg[6:0] & IDX_SEL_MASK[6:0];
        REG_WDATA: wdata_reg <= {w_strb_reg[1] ? w_data_reg[15:8] : wdata_reg[15:8],
          w_data_reg[7:0]};
        REG_IRQ_MASK: irq_mask_reg <= w_data_reg[2:0];
        default: ;
      endcase
    end
  end
  // Commit sequence: wait for check, raise top bit, drop it on echo
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= IDLE;
      wait_reg <= '0;
    end else begin
      case (state_reg)
        IDLE: begin
          wait_reg <= '0;
          if (go) begin
            state_reg <= WAIT_CHECK;
          end
        end
        WAIT_CHECK: begin
          wait_reg <= wait_reg + 2'b01;
          if (wait_reg == 2'b11) begin
            state_reg <= link.invalid ? IDLE : COMMIT;
          end
        end
        COMMIT: begin
          if (link.index_echo[7]) begin
            state_reg <= RELEASE_BIT;
          end
        end
        RELEASE_BIT: begin
          if (!link.index_echo[7]) begin
            state_reg <= IDLE;
          end
        end
        default: state_reg <= IDLE;
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.index_out <= '0;
      link.data_out <= '0;
      link.release_out <= 1'b0;
      link.startup <= 1'b0;
      link.startup_data <= '0;
      link.startup_index <= '0;
    end else begin
      link.index_out <= {state_reg == COMMIT, index_reg};
      link.data_out <= wdata_reg;
      link.release_out <= ctrl_reg[CTRL_RELEASE];
      // Reload pulse bypasses the plausibility check, as a bus start-up does
      link.startup <= aw_hold && w_hold && !s_axi_bvalid && aw_addr_reg == REG_CTRL &&
        w_strb_reg[0] && w_data_reg[CTRL_RELOAD];
      link.startup_data <= wdata_reg;
      link.startup_index <= index_reg;
    end
  end
  // Interrupt status: set wins over read-clear
  assign irq_event = {link.run_blocked, state_reg == WAIT_CHECK && wait_reg == 2'b11 &&
    link.invalid, state_reg == RELEASE_BIT && !link.index_echo[7]};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= '0;
    end else if (s_axi_arvalid && s_axi_arready && s_axi_araddr == REG_IRQ_STATUS) begin
      irq_status_reg <= irq_event;
    end else begin
      irq_status_reg <= irq_status_reg | irq_event;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL: s_axi_rdata <= {16'h0000, ctrl_reg};
        REG_INDEX: s_axi_rdata <= {24'h000000, link.index_echo};
        REG_WDATA: s_axi_rdata <= {16'h0000, wdata_reg};
        REG_STATUS: s_axi_rdata <= {29'h00000000, link.run_blocked, link.invalid,
          state_reg != IDLE};
        REG_RDATA: s_axi_rdata <= {16'h0000, link.data_in};
        REG_IRQ_STATUS: s_axi_rdata <= {29'h00000000, irq_status_reg};
        REG_IRQ_MASK: s_axi_rdata <= {29'h00000000, irq_mask_reg};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ===== param_chan_pkg.sv
// Package: parameter channel constants, indices, error word layout
package param_chan_pkg;
  // ****************************************************************
  // Widths and handshake bits
  // ****************************************************************
  localparam int IDX_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] IDX_COMMIT_BIT = 8'h80;
  localparam logic [7:0] IDX_SEL_MASK = 8'h7f;
  // ****************************************************************
  // Parameter indices (chosen values)
  // ****************************************************************
  localparam logic [6:0] IDX_TEMPERATURE = 7'h26;
  localparam logic [6:0] IDX_SPEED = 7'h27;
  localparam logic [6:0] IDX_PEAK_TORQUE = 7'h28;
  localparam logic [6:0] IDX_RUN_TIME_UPPER = 7'h29;
  localparam logic [6:0] IDX_RUN_TIME_LOWER = 7'h2a;
  localparam logic [6:0] IDX_DRAG_POSITION = 7'h2b;
  localparam logic [6:0] IDX_MOTOR_SUPPLY = 7'h2c;
  localparam logic [6:0] IDX_MOTOR_CURRENT = 7'h2d;
  localparam logic [6:0] IDX_CTRL_SUPPLY = 7'h2e;
  localparam logic [6:0] IDX_ERROR_WORD = 7'h2f;
  localparam logic [6:0] IDX_BACKUP = 7'h7d;
  localparam logic [15:0] BACKUP_KEY = 16'h0055;
  localparam logic [15:0] BACKUP_DONE_DATA = 16'h0000;
  localparam int NUM_PARAMS = 128;
  // Writable parameters: indices below this bound
  localparam logic [6:0] IDX_WRITABLE_LIMIT = 7'h20;
  localparam logic [15:0] PARAM_MAX = 16'h7fff;
  // ****************************************************************
  // Error word bits
  // ****************************************************************
  localparam int ERR_LEARN = 15;
  localparam int ERR_INTERNAL = 14;
  localparam int ERR_OVERTEMP = 13;
  localparam int ERR_MOTOR_MEM = 12;
  localparam int ERR_ADDR_MEM = 11;
  localparam int ERR_PARAM_RESET = 10;
  localparam int ERR_SUPPLY_UNDER16 = 9;
  localparam int ERR_STORED_BAD = 8;
  localparam int ERR_BUS_IF = 7;
  localparam int ERR_BUS_COMM = 6;
  localparam int ERR_RELEASE_RUN = 5;
  localparam int ERR_TARGET_RANGE = 4;
  localparam int ERR_PARAM_INVALID = 3;
  localparam int ERR_ENCODER = 2;
  localparam int ERR_SUPPLY_LOW = 1;
  localparam int ERR_POS_RANGE = 0;
  // Errors that block further runs
  localparam logic [15:0] ERR_BLOCK_MASK = 16'h3905;
  // ****************************************************************
  // Timing: backup completes within 1 s
  // ****************************************************************
  localparam longint CLK_HZ = 250000000;
  localparam int BACKUP_TIME_MS = 1000;
  localparam longint BACKUP_CYCLES = CLK_HZ / 1000 * BACKUP_TIME_MS;
  localparam int CYCLES_PER_MS = 250000;
  // ****************************************************************
  // Master register map (AXI4-Lite byte offsets, chosen)
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_INDEX = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;
  localparam int CTRL_RELEASE = 0;
  localparam int CTRL_GO = 1;
  // Self-clearing: resend the selected index and data as start-up reload
  localparam int CTRL_RELOAD = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_INVALID = 1;
  localparam int ST_RUN_BLOCKED = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_REFUSED = 1;
  localparam int IRQ_ERROR = 2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {OP_READ, OP_WRITE} op_t;
endpackage

// ===== param_chan_if.sv
// Interface: cyclic index/data exchange between master and drive
`timescale 1ns/1ps
interface param_chan_if (input wire logic aclk);
  import param_chan_pkg::*;
  logic [7:0] index_out;
  logic [15:0] data_out;
  logic release_out;
  logic startup;
  logic [15:0] startup_data;
  logic [6:0] startup_index;
  logic [15:0] data_in;
  logic [7:0] index_echo;
  logic invalid;
  logic run_blocked;
  modport master (output index_out, data_out, release_out, startup, startup_data,
    startup_index, input data_in, index_echo, invalid, run_blocked);
  modport drive (input index_out, data_out, release_out, startup, startup_data,
    startup_index, output data_in, index_echo, invalid, run_blocked);
endinterface

// ===== diag_meas.sv
// Module: run-time, drag and peak torque measurement of a drive run
`timescale 1ns/1ps
module diag_meas (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Run phase
  input wire logic run_active,
  input wire logic torque_window,
  input wire logic [15:0] torque_sample,
  input wire logic [15:0] target_speed,
  input wire logic [31:0] actual_pos,
  // Results
  output logic [31:0] run_time_ms,
  output logic [15:0] peak_torque,
  output logic [31:0] drag_position
);
  import param_chan_pkg::*;
  logic [17:0] ms_div_reg;
  logic [31:0] ms_count_reg;
  logic [31:0] theo_pos_reg;
  logic [31:0] start_pos_reg;
  logic run_d_reg;
  logic [15:0] peak_run_reg;
  logic ms_tick;
  assign ms_tick = (ms_div_reg == 18'(CYCLES_PER_MS - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_d_reg <= 1'b0;
    end else begin
      run_d_reg <= run_active;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !run_active || !run_d_reg) begin
      ms_div_reg <= '0;
    end else if (ms_tick) begin
      ms_div_reg <= '0;
    end else begin
      ms_div_reg <= ms_div_reg + 18'h00001;
    end
  end
  // Run time counter frozen at end of run
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_count_reg <= '0;
      run_time_ms <= '0;
    end else if (run_active && !run_d_reg) begin
      ms_count_reg <= '0;
    end else if (run_active && ms_tick) begin
      ms_count_reg <= ms_count_reg + 32'h00000001;
    end else if (!run_active && run_d_reg) begin
      run_time_ms <= ms_count_reg;
    end
  end
  // Theoretical position = target speed times elapsed time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      theo_pos_reg <= '0;
      start_pos_reg <= '0;
      drag_position <= '0;
    end else if (run_active && !run_d_reg) begin
      theo_pos_reg <= '0;
      start_pos_reg <= actual_pos;
    end else if (run_active) begin
      if (ms_tick) begin
        theo_pos_reg <= theo_pos_reg + {16'h0000, target_speed};
      end
      drag_position <= (actual_pos - start_pos_reg) - theo_pos_reg;
    end
  end
  // Peak torque between start-torque end and deceleration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      peak_run_reg <= '0;
      peak_torque <= '0;
    end else if (run_active && !run_d_reg) begin
      peak_run_reg <= '0;
    end else if (run_active && torque_window && torque_sample > peak_run_reg) begin
      peak_run_reg <= torque_sample;
    end else if (!run_active && run_d_reg) begin
      peak_torque <= peak_run_reg;
    end
  end
endmodule

// ===== drive_param_end.sv
// Module: drive end of the parameter channel with diagnostic registers
`timescale 1ns/1ps
module drive_param_end #(
  parameter longint BACKUP_CYCLES_P = param_chan_pkg::BACKUP_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link to master
  param_chan_if.drive link,
  // Measurements and error sources
  input wire logic [15:0] err_sources,
  input wire logic run_active,
  input wire logic torque_window,
  input wire logic [15:0] torque_sample,
  input wire logic [15:0] target_speed,
  input wire logic [31:0] actual_pos,
  input wire logic [15:0] motor_supply_dv,
  input wire logic [15:0] ctrl_supply_dv,
  input wire logic [15:0] motor_current_ma,
  input wire logic [15:0] temperature_c,
  input wire logic [15:0] speed_rpm,
  // Nonvolatile store port
  output logic nv_write,
  output logic [15:0] nv_error_word,
  output logic backup_busy
);
  import param_chan_pkg::*;
  logic [15:0] param_mem [NUM_PARAMS];
  logic [15:0] error_word_reg;
  logic release_d_reg;
  logic commit_d_reg;
  logic [31:0] backup_cnt_reg;
  logic backup_done_reg;
  logic [31:0] run_time_ms;
  logic [15:0] peak_torque;
  logic [31:0] drag_position;
  logic [6:0] sel;
  logic plausible;
  logic commit_edge;
  logic [15:0] readback;
  assign sel = link.index_out[6:0];
  assign commit_edge = link.index_out[7] && !commit_d_reg;
  // ****************************************************************
  // Measurements
  // ****************************************************************
  diag_meas meas (
    .aclk(aclk),
    .aresetn(aresetn),
    .run_active(run_active),
    .torque_window(torque_window),
    .torque_sample(torque_sample),
    .target_speed(target_speed),
    .actual_pos(actual_pos),
    .run_time_ms(run_time_ms),
    .peak_torque(peak_torque),
    .drag_position(drag_position)
  );
  // ****************************************************************
  // Plausibility of the write slot
  // ****************************************************************
  always_comb begin
    if (sel == IDX_BACKUP) begin
      plausible = (link.data_out == BACKUP_KEY);
    end else begin
      plausible = (sel < IDX_WRITABLE_LIMIT) && (link.data_out <= PARAM_MAX);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.invalid <= 1'b0;
    end else begin
      link.invalid <= !plausible;
    end
  end
  // ****************************************************************
  // Parameter store: commit and bus start-up reload
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (link.startup) begin
      param_mem[link.startup_index] <= link.startup_data;
    end else if (commit_edge && plausible && sel != IDX_BACKUP) begin
      param_mem[sel] <= link.data_out;
    end
  end
  // Commit acts once per rising top bit, so a held bit never rewrites
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      commit_d_reg <= 1'b0;
    end else begin
      commit_d_reg <= link.index_out[7];
    end
  end
  // ****************************************************************
  // Backup to nonvolatile memory
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      backup_busy <= 1'b0;
      backup_cnt_reg <= '0;
      backup_done_reg <= 1'b0;
    end else if (commit_edge && plausible && sel == IDX_BACKUP) begin
      backup_busy <= 1'b1;
      backup_cnt_reg <= '0;
      backup_done_reg <= 1'b0;
    end else if (backup_busy) begin
      if (backup_cnt_reg == 32'(BACKUP_CYCLES_P - 1)) begin
        backup_busy <= 1'b0;
        backup_done_reg <= 1'b1;
      end else begin
        backup_cnt_reg <= backup_cnt_reg + 32'h00000001;
      end
    end else if (sel != IDX_BACKUP) begin
      backup_done_reg <= 1'b0;
    end
  end
  // ****************************************************************
  // Error word; release withdrawal clears and saves it
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      release_d_reg <= 1'b0;
    end else begin
      release_d_reg <= link.release_out;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      error_word_reg <= '0;
    end else if (release_d_reg && !link.release_out) begin
      // New sources still set on the clearing edge
      error_word_reg <= err_sources;
      if (run_active) begin
        error_word_reg[ERR_RELEASE_RUN] <= 1'b1;
      end
    end else begin
      error_word_reg <= error_word_reg | err_sources;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nv_write <= 1'b0;
      nv_error_word <= '0;
    end else begin
      nv_write <= (release_d_reg && !link.release_out) || (backup_busy &&
        backup_cnt_reg == '0);
      if ((release_d_reg && !link.release_out) || backup_busy) begin
        nv_error_word <= error_word_reg;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.run_blocked <= 1'b0;
    end else begin
      link.run_blocked <= |(error_word_reg & ERR_BLOCK_MASK);
    end
  end
  // ****************************************************************
  // Readback and echo
  // ****************************************************************
  always_comb begin
    case (sel)
      IDX_TEMPERATURE: readback = temperature_c;
      IDX_SPEED: readback = run_active ? speed_rpm : 16'h0000;
      IDX_PEAK_TORQUE: readback = peak_torque;
      IDX_RUN_TIME_UPPER: readback = run_time_ms[31:16];
      IDX_RUN_TIME_LOWER: readback = run_time_ms[15:0];
      IDX_DRAG_POSITION: readback = drag_position[15:0];
      IDX_MOTOR_SUPPLY: readback = motor_supply_dv;
      IDX_MOTOR_CURRENT: readback = motor_current_ma;
      IDX_CTRL_SUPPLY: readback = ctrl_supply_dv;
      IDX_ERROR_WORD: readback = error_word_reg;
      IDX_BACKUP: readback = backup_done_reg ? BACKUP_DONE_DATA : BACKUP_KEY;
      default: readback = param_mem[sel];
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.data_in <= '0;
      link.index_echo <= '0;
    end else begin
      link.data_in <= readback;
      link.index_echo <= link.index_out;
    end
  end
endmodule

// ===== param_chan_sva.sv
// Checker: assertions on the channel between master and drive ends
`timescale 1ns/1ps
module param_chan_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Channel
  input wire logic [7:0] index_out,
  input wire logic [15:0] data_out,
  input wire logic [15:0] data_in,
  input wire logic [7:0] index_echo,
  input wire logic invalid
);
  import param_chan_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic wr_ok;
  // Only writable indices are watched here; the backup key check is not
  assign wr_ok = index_out[6:0] < IDX_WRITABLE_LIMIT;
  echo_index_a: assert property (index_echo == $past(index_out))
    else $error("index echo wrong");
  bad_value_a: assert property (wr_ok && data_out > PARAM_MAX |=> invalid)
    else $error("implausible value not flagged");
  good_value_a: assert property (wr_ok && data_out <= PARAM_MAX |=> !invalid)
    else $error("plausible value flagged");
  commit_ok_a: assert property ($rose(index_out[7]) |-> !invalid)
    else $error("commit while flagged");
  accept_value_a: assert property (index_out[7] && wr_ok && data_out <= PARAM_MAX
    |-> ##[1:3] data_in == data_out) else $error("value not read back");
  commit_drop_a: assert property ($rose(index_out[7]) |-> ##[1:16] !index_out[7])
    else $error("commit bit stuck");
  index_hold_a: assert property ($changed(index_out[6:0])
    |-> !index_out[7] && !$past(index_out[7])) else $error("index moved under commit");
  backup_done_a: assert property ($rose(data_in == BACKUP_KEY) &&
    index_echo[6:0] == IDX_BACKUP |-> ##[1:40] (data_in == BACKUP_DONE_DATA ||
    index_echo[6:0] != IDX_BACKUP)) else $error("backup not finished");
endmodule

// ===== drive_parameter_channel_diag_test.sv
// Testbench: both channel ends joined, driven over AXI4-Lite
`timescale 1ns/1ps
module drive_parameter_channel_diag_test;
  import param_chan_pkg::*;
  // ************
  // Signals
  // ************
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic rready = 0, run = 0, twin = 0;
  logic awready, wready, bvalid, arready, rvalid, irq, nv_write, backup_busy;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, v;
  logic [1:0] bresp, rresp;
  logic [15:0] err = 0, tsample = 0, nv_word;
  logic [31:0] pos = 0;
  logic [15:0] meas [5] = '{16'd37, 16'd12, 16'd241, 16'd1500, 16'd239};
  int bad_count = 0, checked = 0, nv_cnt = 0;
  param_chan_if link (.aclk(aclk));
  master_param_end i_master_param_end (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq), .link(link.master));
  // Short backup count keeps the run brief
  drive_param_end #(.BACKUP_CYCLES_P(20)) i_drive_param_end (.aclk(aclk),
    .aresetn(aresetn), .link(link.drive), .err_sources(err), .run_active(run),
    .torque_window(twin), .torque_sample(tsample), .target_speed(16'h0000),
    .actual_pos(pos), .motor_supply_dv(meas[2]), .ctrl_supply_dv(meas[4]),
    .motor_current_ma(meas[3]), .temperature_c(meas[0]), .speed_rpm(meas[1]),
    .nv_write(nv_write), .nv_error_word(nv_word), .backup_busy(backup_busy));
  param_chan_sva i_param_chan_sva (.aclk(aclk), .aresetn(aresetn),
    .index_out(link.index_out), .data_out(link.data_out), .data_in(link.data_in),
    .index_echo(link.index_echo), .invalid(link.invalid));
  initial begin
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) if (nv_write) nv_cnt <= nv_cnt + 1;
  // ************
  // Tasks
  // ************
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [1:0] resp_of(logic [7:0] a);
    return (a <= REG_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
  endfunction
  task automatic wr(logic [7:0] a, logic [31:0] d);
    bit ad = 0, dd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (awready) ad = 1;
      if (wready) dd = 1;
      if (ad) awvalid <= 1'b0;
      if (dd) wvalid <= 1'b0;
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", bresp, resp_of(a));
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    chk("rresp", rresp, resp_of(a));
  endtask
  task automatic rchk(string nm, logic [7:0] a, logic [31:0] e);
    rd(a, v);
    chk(nm, v, e);
  endtask
  // Readback lags the index by a register stage on each side
  task automatic mchk(string nm, logic [6:0] i, logic [31:0] e);
    wr(REG_INDEX, {25'h0, i});
    repeat (4) @(posedge aclk);
    rchk(nm, REG_RDATA, e);
  endtask
  task automatic put(logic [6:0] i, logic [15:0] d);
    wr(REG_WDATA, {16'h0, d});
    wr(REG_INDEX, {25'h0, i});
    wr(REG_CTRL, 32'h3);
    do rd(REG_STATUS, v); while (v[ST_BUSY] !== 1'b0);
  endtask
  task automatic end_of_test;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    end_of_test;
  end
  // ************
  // Tests
  // ************
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    wr(REG_IRQ_MASK, 32'h1);
    put(7'h05, 16'h1234);
    rchk("rdata", REG_RDATA, 32'h1234);
    chk("irq", irq, 1'b1);
    rchk("irq_status", REG_IRQ_STATUS, 32'h1);
    rchk("irq_status", REG_IRQ_STATUS, 32'h0);
    chk("irq", irq, 1'b0);
    put(7'h05, 16'h8000);
    rd(REG_STATUS, v);
    chk("invalid", v[ST_INVALID], 1'b1);
    rchk("rdata", REG_RDATA, 32'h1234);
    chk("irq", irq, 1'b0);
    rchk("irq_status", REG_IRQ_STATUS, 32'h2);
    wr(REG_WDATA, 32'h9abc);
    wr(REG_INDEX, 32'h6);
    wr(REG_CTRL, 32'h5);
    mchk("reload", 7'h06, 32'h9abc);
    for (int i = 0; i < 16; i++) begin
      err <= 16'h1 << i;
      wr(REG_CTRL, 32'h1);
      err <= 16'h0;
      mchk("error_word", IDX_ERROR_WORD, 32'h1 << i);
      rd(REG_STATUS, v);
      chk("run_blocked", v[ST_RUN_BLOCKED], ERR_BLOCK_MASK[i]);
      wr(REG_CTRL, 32'h0);
      repeat (4) @(posedge aclk);
      chk("nv_word", nv_word, 32'h1 << i);
      chk("nv_count", nv_cnt, i + 1);
      mchk("error_word", IDX_ERROR_WORD, 32'h0);
      rd(REG_STATUS, v);
      chk("run_blocked", v[ST_RUN_BLOCKED], 1'b0);
    end
    run <= 1'b1;
    twin <= 1'b1;
    tsample <= 16'h0123;
    mchk("speed", IDX_SPEED, 32'd12);
    pos <= 32'h0000_0005;
    mchk("drag", IDX_DRAG_POSITION, 32'h5);
    tsample <= 16'h0042;
    twin <= 1'b0;
    run <= 1'b0;
    mchk("peak_torque", IDX_PEAK_TORQUE, 32'h0123);
    // Run lasted far less than a millisecond
    mchk("run_time_upper", IDX_RUN_TIME_UPPER, 32'h0);
    mchk("run_time_lower", IDX_RUN_TIME_LOWER, 32'h0);
    mchk("temperature", IDX_TEMPERATURE, 32'd37);
    mchk("motor_supply", IDX_MOTOR_SUPPLY, 32'd241);
    mchk("motor_current", IDX_MOTOR_CURRENT, 32'd1500);
    mchk("ctrl_supply", IDX_CTRL_SUPPLY, 32'd239);
    put(IDX_BACKUP, BACKUP_KEY);
    chk("backup_busy", backup_busy, 1'b1);
    while (backup_busy !== 1'b0) @(posedge aclk);
    mchk("backup", IDX_BACKUP, 32'h0);
    wr(8'h1c, 32'h0);
    rd(8'h1c, v);
    end_of_test;
  end
endmodule
